// ### src/tbs_pkg.sv
// package for the bulk/control split transaction buffer block
package tbs_pkg;
   localparam int NUM_BUFS = 2;
   localparam int IDX_W = 1;
   localparam int DATA_W = 8;
   localparam int MAX_BYTES = 8;
   localparam int CNT_W = 4;
   localparam int ERR_W = 2;
   localparam logic [ERR_W-1:0] ERR_LIMIT = 2'h3;
   localparam logic [ERR_W-1:0] ERR_ZERO = 2'h0;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   typedef enum logic [1:0] {
      TBS_ST_OLD = 2'b00,
      TBS_ST_PENDING = 2'b01,
      TBS_ST_READY = 2'b10
   } tbs_state_e;

   typedef enum logic [1:0] {
      TBS_RES_NAK = 2'b00,
      TBS_RES_STALL = 2'b01,
      TBS_RES_ACK = 2'b10
   } tbs_res_e;

   typedef enum logic [2:0] {
      TBS_HS_NONE = 3'b000,
      TBS_HS_ACK = 3'b001,
      TBS_HS_NAK = 3'b010,
      TBS_HS_STALL = 3'b011,
      TBS_HS_NYET = 3'b100
   } tbs_hs_e;

   // downstream attempt outcome
   typedef enum logic [2:0] {
      TBS_DN_ACK = 3'b000,
      TBS_DN_NAK = 3'b001,
      TBS_DN_STALL = 3'b010,
      TBS_DN_ERR = 3'b011,
      TBS_DN_EOF = 3'b100
   } tbs_dn_e;

   typedef enum logic [1:0] {
      TBS_DS_IDLE = 2'b00,
      TBS_DS_RUN = 2'b01,
      TBS_DS_WAIT = 2'b10
   } tbs_ds_e;

   // endpoint identity of a split
   typedef struct packed {
      logic [6:0] dev_addr;
      logic [3:0] endpt;
      logic dir_in;
      logic is_ctrl;
      logic is_setup;
   } tbs_tok_s;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic last;
   } tbs_byte_s;
endpackage : tbs_pkg

// ### src/tbs_split_buffer.sv
// bulk/control split transaction buffers with high-speed and downstream handlers
`timescale 1ns/1ps
module tbs_split_buffer (
   input wire logic MCLK_I,
   input wire logic NRST_I,
   // high-speed side: split token, one-cycle request
   input wire logic SS_REQ_I,
   input wire logic CS_REQ_I,
   input wire tbs_pkg::tbs_tok_s TOK_I,
   // OUT/SETUP payload bytes following an accepted start-split
   input wire logic SS_DVALID_I,
   input wire tbs_pkg::tbs_byte_s SS_DATA_I,
   output logic [2:0] HS_HANDSHAKE_O,
   output logic HS_RESP_VALID_O,
   // complete-split IN data return
   output logic CS_DVALID_O,
   output tbs_pkg::tbs_byte_s CS_DATA_O,
   // downstream handler: transaction request and outcome
   output logic DN_START_O,
   output tbs_pkg::tbs_tok_s DN_TOK_O,
   output logic [tbs_pkg::IDX_W-1:0] DN_IDX_O,
   output logic [tbs_pkg::CNT_W-1:0] DN_LEN_O,
   input wire logic DN_DONE_I,
   input wire logic [2:0] DN_RESULT_I,
   input wire logic DN_RDVALID_I,
   input wire logic [tbs_pkg::DATA_W-1:0] DN_RDATA_I,
   input wire logic [tbs_pkg::CNT_W-1:0] DN_RADDR_I,
   output logic [tbs_pkg::DATA_W-1:0] DN_WDATA_O,
   input wire logic DN_WADDR_VALID_I,
   output logic [1:0] BUF0_STATE_O,
   output logic [1:0] BUF1_STATE_O
);
   localparam int NB = tbs_pkg::NUM_BUFS;

   tbs_pkg::tbs_state_e st_r [NB];
   tbs_pkg::tbs_res_e res_r [NB];
   tbs_pkg::tbs_tok_s tok_r [NB];
   logic [tbs_pkg::DATA_W-1:0] mem_r [NB][tbs_pkg::MAX_BYTES];
   logic [tbs_pkg::CNT_W-1:0] len_r [NB];

   // combinational search over the buffers
   logic hit;
   logic [tbs_pkg::IDX_W-1:0] hit_idx;
   logic free;
   logic [tbs_pkg::IDX_W-1:0] free_idx;
   always_comb begin
      hit = 1'b0;
      hit_idx = '0;
      free = 1'b0;
      free_idx = '0;
      for (int i = 0; i < NB; i++) begin
         if (!hit && tok_r[i].endpt == TOK_I.endpt && tok_r[i].dev_addr == TOK_I.dev_addr &&
             (TOK_I.is_ctrl || tok_r[i].dir_in == TOK_I.dir_in) && st_r[i] != tbs_pkg::TBS_ST_OLD) begin
            hit = 1'b1;
            hit_idx = tbs_pkg::IDX_W'(i);
         end
         if (!free && st_r[i] == tbs_pkg::TBS_ST_OLD) begin
            free = 1'b1;
            free_idx = tbs_pkg::IDX_W'(i);
         end
      end
   end

   // an old buffer takes part in no match, so a repeated complete-split is stalled
   // high-speed answer
   logic [2:0] hs_nxt;
   always_comb begin
      hs_nxt = tbs_pkg::TBS_HS_NONE;
      if (SS_REQ_I) begin
         if (hit) hs_nxt = tbs_pkg::TBS_HS_ACK;
         else if (free) hs_nxt = tbs_pkg::TBS_HS_ACK;
         else hs_nxt = tbs_pkg::TBS_HS_NAK;
      end else if (CS_REQ_I) begin
         if (hit && st_r[hit_idx] == tbs_pkg::TBS_ST_PENDING) hs_nxt = tbs_pkg::TBS_HS_NYET;
         else if (hit) begin
            case (res_r[hit_idx])
               tbs_pkg::TBS_RES_ACK: hs_nxt = tbs_pkg::TBS_HS_ACK;
               tbs_pkg::TBS_RES_NAK: hs_nxt = tbs_pkg::TBS_HS_NAK;
               default: hs_nxt = tbs_pkg::TBS_HS_STALL;
            endcase
         end else hs_nxt = tbs_pkg::TBS_HS_STALL;
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         HS_HANDSHAKE_O <= tbs_pkg::TBS_HS_NONE;
         HS_RESP_VALID_O <= 1'b0;
      end else begin
         HS_HANDSHAKE_O <= hs_nxt;
         HS_RESP_VALID_O <= SS_REQ_I | CS_REQ_I;
      end
   end

   // data capture for a newly accepted start-split
   logic wr_act_r;
   logic [tbs_pkg::IDX_W-1:0] wr_idx_r;
   logic [tbs_pkg::CNT_W-1:0] wr_cnt_r;
   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         wr_act_r <= 1'b0;
         wr_idx_r <= '0;
         wr_cnt_r <= tbs_pkg::CNT_ZERO;
      end else if (SS_REQ_I && !hit && free && !TOK_I.dir_in) begin
         wr_act_r <= 1'b1;
         wr_idx_r <= free_idx;
         wr_cnt_r <= tbs_pkg::CNT_ZERO;
      end else if (wr_act_r && SS_DVALID_I) begin
         if (wr_cnt_r < tbs_pkg::CNT_W'(tbs_pkg::MAX_BYTES)) wr_cnt_r <= wr_cnt_r + tbs_pkg::CNT_ONE;
         if (SS_DATA_I.last) wr_act_r <= 1'b0;
      end
   end

   // downstream handler
   tbs_pkg::tbs_ds_e ds_r;
   logic [tbs_pkg::IDX_W-1:0] ds_idx_r;
   logic [tbs_pkg::ERR_W-1:0] ds_err_r;
   logic [tbs_pkg::ERR_W-1:0] ds_err_nxt;
   logic ds_pick;
   logic [tbs_pkg::IDX_W-1:0] ds_pick_idx;
   always_comb begin
      ds_pick = 1'b0;
      ds_pick_idx = '0;
      for (int i = 0; i < NB; i++) begin
         if (!ds_pick && st_r[i] == tbs_pkg::TBS_ST_PENDING && !(wr_act_r && wr_idx_r == tbs_pkg::IDX_W'(i))) begin
            ds_pick = 1'b1;
            ds_pick_idx = tbs_pkg::IDX_W'(i);
         end
      end
      ds_err_nxt = ds_err_r + 2'h1;
   end
   logic ds_fail;
   assign ds_fail = DN_RESULT_I == tbs_pkg::TBS_DN_ERR || DN_RESULT_I == tbs_pkg::TBS_DN_EOF;
   logic ds_finish;
   assign ds_finish = ds_r == tbs_pkg::TBS_DS_WAIT && DN_DONE_I &&
                      (!ds_fail || ds_err_nxt == tbs_pkg::ERR_LIMIT);

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         ds_r <= tbs_pkg::TBS_DS_IDLE;
         ds_idx_r <= '0;
         ds_err_r <= tbs_pkg::ERR_ZERO;
         DN_START_O <= 1'b0;
         DN_TOK_O <= '0;
         DN_IDX_O <= '0;
         DN_LEN_O <= tbs_pkg::CNT_ZERO;
      end else begin
         DN_START_O <= 1'b0;
         case (ds_r)
            tbs_pkg::TBS_DS_IDLE: begin
               if (ds_pick) begin
                  ds_idx_r <= ds_pick_idx;
                  ds_err_r <= tbs_pkg::ERR_ZERO;
                  ds_r <= tbs_pkg::TBS_DS_RUN;
               end
            end
            tbs_pkg::TBS_DS_RUN: begin
               DN_START_O <= 1'b1;
               DN_TOK_O <= tok_r[ds_idx_r];
               DN_IDX_O <= ds_idx_r;
               DN_LEN_O <= len_r[ds_idx_r];
               ds_r <= tbs_pkg::TBS_DS_WAIT;
            end
            tbs_pkg::TBS_DS_WAIT: begin
               if (DN_DONE_I) begin
                  if (ds_finish) ds_r <= tbs_pkg::TBS_DS_IDLE;
                  else begin
                     ds_err_r <= ds_err_nxt;
                     ds_r <= tbs_pkg::TBS_DS_RUN;
                  end
               end
            end
            default: ds_r <= tbs_pkg::TBS_DS_IDLE;
         endcase
      end
   end

   always_ff @(posedge MCLK_I) begin
      DN_WDATA_O <= mem_r[ds_idx_r][DN_RADDR_I[2:0]];
   end

   // buffer state, result and contents, one loop per buffer
   for (genvar g = 0; g < NB; g++) begin : g_buf
      always_ff @(posedge MCLK_I) begin
         if (!NRST_I) begin
            st_r[g] <= tbs_pkg::TBS_ST_OLD;
            res_r[g] <= tbs_pkg::TBS_RES_NAK;
            tok_r[g] <= '0;
            len_r[g] <= tbs_pkg::CNT_ZERO;
         end else begin
            if (SS_REQ_I && !hit && free && free_idx == tbs_pkg::IDX_W'(g)) begin
               st_r[g] <= tbs_pkg::TBS_ST_PENDING;
               tok_r[g] <= TOK_I;
               len_r[g] <= tbs_pkg::CNT_ZERO;
            end else if (CS_REQ_I && hit && hit_idx == tbs_pkg::IDX_W'(g) && st_r[g] == tbs_pkg::TBS_ST_READY) begin
               st_r[g] <= tbs_pkg::TBS_ST_OLD;
            end else if (ds_finish && ds_idx_r == tbs_pkg::IDX_W'(g)) begin
               st_r[g] <= tbs_pkg::TBS_ST_READY;
               if (ds_fail) res_r[g] <= tbs_pkg::TBS_RES_STALL;
               else if (DN_RESULT_I == tbs_pkg::TBS_DN_ACK) res_r[g] <= tbs_pkg::TBS_RES_ACK;
               else if (DN_RESULT_I == tbs_pkg::TBS_DN_NAK) res_r[g] <= tbs_pkg::TBS_RES_NAK;
               else res_r[g] <= tbs_pkg::TBS_RES_STALL;
            end
            // bytes past the buffer are dropped and must not stretch the length
            if (wr_act_r && SS_DVALID_I && wr_idx_r == tbs_pkg::IDX_W'(g) &&
                wr_cnt_r < tbs_pkg::CNT_W'(tbs_pkg::MAX_BYTES))
               len_r[g] <= wr_cnt_r + tbs_pkg::CNT_ONE;
            if (ds_r == tbs_pkg::TBS_DS_RUN && ds_idx_r == tbs_pkg::IDX_W'(g) && tok_r[g].dir_in) len_r[g] <= tbs_pkg::CNT_ZERO;
            if (DN_RDVALID_I && ds_idx_r == tbs_pkg::IDX_W'(g) && DN_RADDR_I < tbs_pkg::CNT_W'(tbs_pkg::MAX_BYTES))
               len_r[g] <= DN_RADDR_I + tbs_pkg::CNT_ONE;
         end
      end
      // payload storage carries no reset: the complete-split return reads only bytes below len_r, but DN_WDATA_O reads any address
      always_ff @(posedge MCLK_I) begin
         if (wr_act_r && SS_DVALID_I && wr_idx_r == tbs_pkg::IDX_W'(g) && wr_cnt_r < tbs_pkg::CNT_W'(tbs_pkg::MAX_BYTES))
            mem_r[g][wr_cnt_r[2:0]] <= SS_DATA_I.data;
         else if (DN_RDVALID_I && ds_idx_r == tbs_pkg::IDX_W'(g) && DN_RADDR_I < tbs_pkg::CNT_W'(tbs_pkg::MAX_BYTES))
            mem_r[g][DN_RADDR_I[2:0]] <= DN_RDATA_I;
      end
   end

   // IN data return after an ACK complete-split
   logic rd_act_r;
   logic [tbs_pkg::IDX_W-1:0] rd_idx_r;
   logic [tbs_pkg::CNT_W-1:0] rd_cnt_r;
   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         rd_act_r <= 1'b0;
         rd_idx_r <= '0;
         rd_cnt_r <= tbs_pkg::CNT_ZERO;
         CS_DVALID_O <= 1'b0;
         CS_DATA_O <= '0;
      end else begin
         CS_DVALID_O <= 1'b0;
         if (CS_REQ_I && hit && st_r[hit_idx] == tbs_pkg::TBS_ST_READY && tok_r[hit_idx].dir_in &&
             res_r[hit_idx] == tbs_pkg::TBS_RES_ACK && len_r[hit_idx] != tbs_pkg::CNT_ZERO) begin
            rd_act_r <= 1'b1;
            rd_idx_r <= hit_idx;
            rd_cnt_r <= tbs_pkg::CNT_ZERO;
         end else if (rd_act_r) begin
            CS_DVALID_O <= 1'b1;
            CS_DATA_O.data <= mem_r[rd_idx_r][rd_cnt_r[2:0]];
            CS_DATA_O.last <= rd_cnt_r + tbs_pkg::CNT_ONE == len_r[rd_idx_r];
            rd_cnt_r <= rd_cnt_r + tbs_pkg::CNT_ONE;
            if (rd_cnt_r + tbs_pkg::CNT_ONE == len_r[rd_idx_r]) rd_act_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         BUF0_STATE_O <= tbs_pkg::TBS_ST_OLD;
         BUF1_STATE_O <= tbs_pkg::TBS_ST_OLD;
      end else begin
         BUF0_STATE_O <= st_r[0];
         BUF1_STATE_O <= st_r[1];
      end
   end
endmodule : tbs_split_buffer

// ### verif/tbs_split_buffer_assertions.sv
// port-level assertion checker for the split transaction buffer
`timescale 1ns/1ps
module tbs_split_buffer_chk (
   input wire logic MCLK_I,
   input wire logic NRST_I,
   input wire logic SS_REQ_I,
   input wire logic CS_REQ_I,
   input wire logic [2:0] HS_HANDSHAKE_O,
   input wire logic HS_RESP_VALID_O,
   input wire logic DN_START_O,
   input wire logic [tbs_pkg::IDX_W-1:0] DN_IDX_O,
   input wire logic DN_DONE_I,
   input wire logic [2:0] DN_RESULT_I,
   input wire logic [1:0] BUF0_STATE_O,
   input wire logic [1:0] BUF1_STATE_O
);
   logic [1:0] errs_r;
   logic dn_err;
   logic any_old;
   logic [1:0] st_dn;
   assign dn_err = DN_DONE_I && (DN_RESULT_I == 3'h3 || DN_RESULT_I == 3'h4);
   assign any_old = BUF0_STATE_O == 2'h0 || BUF1_STATE_O == 2'h0;
   assign st_dn = DN_IDX_O[0] ? BUF1_STATE_O : BUF0_STATE_O;
   // one downstream transaction runs at a time, so one attempt count is enough
   always_ff @(posedge MCLK_I) begin
      if (!NRST_I) begin
         errs_r <= 2'h0;
      end else if (DN_DONE_I) begin
         errs_r <= (dn_err && errs_r < 2'h2) ? errs_r + 2'h1 : 2'h0;
      end
   end
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);
   a_ss_free_ack: assert property (SS_REQ_I && any_old |=> HS_RESP_VALID_O && HS_HANDSHAKE_O == 3'h1)
      else $error("start-split with a free buffer not acknowledged");
   a_cs_nomatch: assert property (CS_REQ_I && !SS_REQ_I && !(BUF0_STATE_O | BUF1_STATE_O) |=> HS_HANDSHAKE_O == 3'h3)
      else $error("complete-split without buffer not stalled");
   a_nyet_pend: assert property (HS_RESP_VALID_O && HS_HANDSHAKE_O == 3'h4 |-> BUF0_STATE_O == 2'h1 || BUF1_STATE_O == 2'h1)
      else $error("nyet without a pending buffer");
   a_ready_done: assert property (DN_DONE_I && (!dn_err || errs_r == 2'h2) |-> ##[1:2] st_dn == 2'h2)
      else $error("buffer not ready after downstream end");
   a_err_retry: assert property (dn_err && errs_r < 2'h2 |-> ##[1:2] DN_START_O)
      else $error("downstream error not retried");
   a_no_retry_hs: assert property (DN_DONE_I && !dn_err |-> ##2 !DN_START_O)
      else $error("retry after a handshake");
   a_start_pend: assert property (DN_START_O |-> st_dn == 2'h1)
      else $error("downstream start on a buffer not pending");
   a_ready_src: assert property (BUF0_STATE_O == 2'h2 && $past(BUF0_STATE_O) == 2'h1 |-> $past(DN_DONE_I) || $past(DN_DONE_I, 2))
      else $error("buffer ready without downstream end");
   a_old_after_cs: assert property (BUF0_STATE_O == 2'h0 && $past(BUF0_STATE_O) == 2'h2 |-> $past(CS_REQ_I) || $past(CS_REQ_I, 2))
      else $error("ready buffer freed without complete-split");
   a_reset_old: assert property ($rose(NRST_I) |-> !(BUF0_STATE_O | BUF1_STATE_O) && !DN_START_O)
      else $error("buffers not old after reset");
   c_nyet: cover property (HS_RESP_VALID_O && HS_HANDSHAKE_O == 3'h4);
   c_full_nak: cover property (SS_REQ_I && !any_old ##1 HS_HANDSHAKE_O == 3'h2);
   c_third_err: cover property (dn_err && errs_r == 2'h2);
endmodule : tbs_split_buffer_chk
bind tbs_split_buffer tbs_split_buffer_chk u_chk (.MCLK_I, .NRST_I, .SS_REQ_I, .CS_REQ_I, .HS_HANDSHAKE_O,
   .HS_RESP_VALID_O, .DN_START_O, .DN_IDX_O, .DN_DONE_I, .DN_RESULT_I, .BUF0_STATE_O, .BUF1_STATE_O);

// ### verif/tbs_dn_model.sv
// downstream full-/low-speed bus responder
`timescale 1ns/1ps
module tbs_dn_model (
   input wire logic clk_i,
   input wire logic start_i,
   input wire tbs_pkg::tbs_tok_s tok_i,
   input wire logic [3:0] len_i,
   input wire logic [7:0] wdata_i,
   input wire logic [8:0] seq_i,
   input wire logic [5:0] dly_i,
   output logic done_o = 1'b0,
   output logic [2:0] res_o = 3'h7,
   output logic rdv_o = 1'b0,
   output logic [7:0] rdata_o = 8'h00,
   output logic [3:0] raddr_o = 4'h0,
   output logic [7:0] wsum_o = 8'h00
);
   int n = 0;
   int a;
   logic [7:0] x;
   logic [2:0] r;
   always begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
         x = 8'h00;
         repeat (dly_i) @(posedge clk_i);
         // outside the IN bytes the data lines keep changing, never a stale copy
         for (a = 0; a <= 8; a++) begin
            raddr_o <= a[3:0];
            rdv_o <= tok_i.dir_in && a < 4;
            rdata_o <= a[7:0] ^ ((a < 4) ? 8'ha5 : 8'h5a);
            @(posedge clk_i);
            if (a > 0 && a <= len_i && !tok_i.dir_in) x ^= wdata_i;
         end
         // attempt n takes its outcome from the bench's script
         r = seq_i[3*n +: 3];
         wsum_o <= x;
         res_o <= r;
         done_o <= 1'b1;
         rdv_o <= 1'b0;
         @(posedge clk_i);
         done_o <= 1'b0;
         res_o <= ~r;
         n = (r > 3'h2 && n < 2) ? n + 1 : 0;
      end
   end
endmodule : tbs_dn_model

// ### verif/test_tbs_split_buffer.sv
// self-checking bench for the split transaction buffer
`timescale 1ns/1ps
module test_tbs_split_buffer;
   logic mclk = 1'b0, nrst = 1'b0, ss_req = 1'b0, cs_req = 1'b0, ss_dv = 1'b0;
   tbs_pkg::tbs_tok_s tok = '0;
   tbs_pkg::tbs_byte_s ss_d = '0;
   logic [8:0] seq = 9'h000;
   logic [5:0] dly = 6'h0a;
   logic [2:0] hs, dn_res, h;
   logic hs_vld, cs_dv, dn_start, dn_done, rdv;
   tbs_pkg::tbs_byte_s cs_d;
   tbs_pkg::tbs_tok_s dn_tok;
   logic [0:0] dn_idx;
   logic [3:0] dn_len, raddr;
   logic [7:0] rdata, wdata, wsum, xs;
   logic [1:0] b0, b1;
   int fail_count = 0;
   int cmp_count = 0;
   always #12.5 mclk = ~mclk;
   tbs_split_buffer dut (.MCLK_I(mclk), .NRST_I(nrst), .SS_REQ_I(ss_req), .CS_REQ_I(cs_req), .TOK_I(tok),
      .SS_DVALID_I(ss_dv), .SS_DATA_I(ss_d), .HS_HANDSHAKE_O(hs), .HS_RESP_VALID_O(hs_vld), .CS_DVALID_O(cs_dv),
      .CS_DATA_O(cs_d), .DN_START_O(dn_start), .DN_TOK_O(dn_tok), .DN_IDX_O(dn_idx), .DN_LEN_O(dn_len),
      .DN_DONE_I(dn_done), .DN_RESULT_I(dn_res), .DN_RDVALID_I(rdv), .DN_RDATA_I(rdata), .DN_RADDR_I(raddr),
      .DN_WDATA_O(wdata), .DN_WADDR_VALID_I(1'b0), .BUF0_STATE_O(b0), .BUF1_STATE_O(b1));
   tbs_dn_model u_dn (.clk_i(mclk), .start_i(dn_start), .tok_i(dn_tok), .len_i(dn_len), .wdata_i(wdata),
      .seq_i(seq), .dly_i(dly), .done_o(dn_done), .res_o(dn_res), .rdv_o(rdv), .rdata_o(rdata), .raddr_o(raddr),
      .wsum_o(wsum));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task summarize;
      if (fail_count == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   function logic [2:0] exp_hs(input logic [8:0] s);
      for (int i = 0; i < 3; i++) if (s[3*i +: 3] < 3'h3) return s[3*i +: 3] + 3'h1;
      return 3'h3;
   endfunction : exp_hs
   function logic [7:0] used;
      return 8'(b0 !== 2'h0) + 8'(b1 !== 2'h0);
   endfunction : used
   task req(input logic c, input tbs_pkg::tbs_tok_s t);
      @(posedge mclk);
      cs_req <= c;
      ss_req <= !c;
      tok <= t;
      @(posedge mclk);
      cs_req <= 1'b0;
      ss_req <= 1'b0;
      h = 3'h7;
      for (int i = 0; i < 4 && h === 3'h7; i++) begin
         @(posedge mclk);
         if (hs_vld === 1'b1) h = hs;
      end
   endtask : req
   // complete-split until the answer is no longer nyet, then IN bytes
   task poll(input tbs_pkg::tbs_tok_s t);
      int k;
      int strikes;
      k = 0;
      strikes = 0;
      h = 3'h4;
      // nyet is a normal answer; a missing answer is a strike, retried at once up to three
      for (int i = 0; i < 80 && (h === 3'h4 || (h === 3'h7 && strikes < 3)); i++) begin
         req(1'b1, t);
         strikes = (h === 3'h7) ? strikes + 1 : 0;
      end
      for (int i = 0; i < 12 && h === 3'h1 && t.dir_in; i++) begin
         @(posedge mclk);
         if (cs_dv === 1'b1) begin
            if (k < 4) chk("in_byte", k[7:0] ^ 8'ha5, cs_d.data);
            k++;
            if (cs_d.last === 1'b1) break;
         end
      end
      if (h === 3'h1 && t.dir_in) chk("in_count", 8'h04, k[7:0]);
   endtask : poll
   task txn(input tbs_pkg::tbs_tok_s t, input logic [8:0] s, input int n);
      logic [7:0] d;
      seq <= s;
      xs = 8'h00;
      // a start-split that got no answer is sent again, up to three strikes
      for (int i = 0; i < 3 && (i == 0 || h === 3'h7); i++) req(1'b0, t);
      chk("ss_hs", 8'h01, 8'(h));
      for (int i = 0; i < n && !t.dir_in; i++) begin
         d = 8'($urandom);
         xs ^= d;
         ss_dv <= 1'b1;
         ss_d <= {d, i == n - 1};
         @(posedge mclk);
      end
      ss_dv <= 1'b0;
      req(1'b1, t);
      chk("cs_early", 8'h04, 8'(h));
      poll(t);
      chk("cs_hs", 8'(exp_hs(s)), 8'(h));
      if (!t.dir_in) chk("out_sum", xs, wsum);
      // the buffer is old after any answer, so a repeated complete-split is stalled; skipped when the first answer was already a stall
      if (exp_hs(s) != 3'h3) begin
         req(1'b1, t);
         chk("cs_again", 8'h03, 8'(h));
      end
   endtask : txn
   initial begin
      logic [8:0] cs [6];
      tbs_pkg::tbs_tok_s t;
      logic [8:0] s;
      cs = '{9'h000, 9'h001, 9'h002, 9'h0db, 9'h01c, 9'h063};
      void'($urandom(32'h4c06));
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      chk("used_rst", 8'h00, used());
      for (int i = 0; i < 6; i++) txn({7'h11, 4'h3, i[0], 2'b00}, cs[i], 8);
      // fill both buffers, then a third endpoint has nowhere to go
      dly <= 6'h28;
      seq <= 9'h000;
      req(1'b0, {7'h05, 4'h1, 3'b110});
      @(negedge mclk);
      chk("used_a", 8'h01, used());
      req(1'b0, {7'h05, 4'h1, 3'b010});
      chk("ctl_dir", 8'h01, 8'(h));
      chk("used_a2", 8'h01, used());
      req(1'b0, {7'h05, 4'h2, 3'b100});
      @(negedge mclk);
      chk("used_b", 8'h02, used());
      req(1'b0, {7'h05, 4'h2, 3'b000});
      chk("full_nak", 8'h02, 8'(h));
      chk("used_f", 8'h02, used());
      poll({7'h05, 4'h1, 3'b010});
      chk("cs_a", 8'h01, 8'(h));
      poll({7'h05, 4'h2, 3'b100});
      chk("cs_b", 8'h01, 8'(h));
      for (int i = 0; i < 16; i++) begin
         // a nak brings the same endpoint's start-split back, any other answer moves on
         if (i == 0 || exp_hs(s) != 3'h2) t = 14'($urandom);
         t.is_setup = 1'b0;
         s = {3'($urandom_range(4)), 3'($urandom_range(4)), 3'($urandom_range(4))};
         dly <= 6'(10 + $urandom_range(20));
         txn(t, s, 1 + $urandom_range(7));
      end
      summarize();
   end
   initial begin
      repeat (40000) @(posedge mclk);
      fail_count++;
      summarize();
   end
endmodule : test_tbs_split_buffer
